// ==== vcia_pkg.sv ====
package vcia_pkg;

  localparam logic [3:0]  CP_COPROC    = 4'hf;
  localparam logic [3:0]  CP_CRN       = 4'hc;
  localparam logic [3:0]  CP_CRM       = 4'hc;
  localparam logic [2:0]  CP_OPC1      = 3'h0;
  localparam logic [2:0]  OPC2_ACK1    = 3'h0;
  localparam logic [2:0]  OPC2_EN0     = 3'h6;
  localparam logic [2:0]  OPC2_EN1     = 3'h7;
  localparam logic [23:0] SPURIOUS_ID  = 24'h0003ff;
  localparam logic [1:0]  EL_1         = 2'h1;
  localparam logic        ENABLE_RST   = 1'h0;
  localparam logic [2:0]  ID_WIDTH_FIELD_16    = 3'h0;
  localparam logic [2:0]  ID_WIDTH_FIELD_24    = 3'h1;
  localparam int          ID_NARROW    = 16;
  localparam int          ID_WIDE      = 24;

  typedef enum logic [6:0] {
    ST_OK       = 7'h01,
    ST_PHYS     = 7'h02,
    ST_UNDEF    = 7'h04,
    ST_TRAP_EL1 = 7'h08,
    ST_TRAP_EL2 = 7'h10,
    ST_TRAP_HYP = 7'h20,
    ST_NOREG    = 7'h40
  } vcia_status_e;

  typedef enum logic [3:0] {
    REG_NONE = 4'h1,
    REG_ACK1 = 4'h2,
    REG_EN0  = 4'h4,
    REG_EN1  = 4'h8
  } vcia_reg_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [2:0]  opc1;
    logic [2:0]  opc2;
    logic [3:0]  crn;
    logic [3:0]  coproc;
    logic [3:0]  crm;
    logic [31:0] wdata;
  } vcia_req_s;

  typedef struct packed {
    logic [1:0] el;
    logic       nonsecure_state_bit;
    logic       hyp_irq_routing_bit;
    logic       hyp_fiq_routing_bit;
    logic       sysreg_iface_enable_32;
    logic       sysreg_iface_enable_el1;
    logic       el2_present;
    logic       el2_uses_32;
    logic       hyp_c12_trap_bit;
    logic       trap_all_group0;
    logic       trap_all_group1;
  } vcia_ctx_s;

  typedef struct packed {
    logic        valid;
    logic        group1;
    logic        can_signal;
    logic [23:0] interrupt_id;
  } vcia_hppi_s;

  typedef struct packed {
    logic         valid;
    vcia_status_e status;
    vcia_reg_e    target;
    logic [31:0]  rdata;
  } vcia_rsp_s;

  typedef struct packed {
    logic        grp0_en;
    logic        grp1_en;
    vcia_rsp_s   rsp;
    logic        ack_valid;
    logic [23:0] ack_id;
    logic        hold;
  } vcia_state_s;

endpackage

// ==== vcia_top.sv ====
`timescale 1ns/10ps
module vcia_top
  import vcia_pkg::*;
#(
  parameter int ID_BITS = 16
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire vcia_req_s   req,
  input  wire vcia_ctx_s   ctx,
  input  wire vcia_hppi_s  hppi,
  output vcia_rsp_s        rsp,
  output logic             ack_valid,
  output logic [23:0]      ack_id,
  output logic             virq,
  output logic             vfiq,
  output logic             grp0_enabled,
  output logic             grp1_enabled,
  output logic [2:0]       id_width_field
);

  if (ID_BITS != ID_NARROW && ID_BITS != ID_WIDE) begin : g_chk
    $error("ID_BITS must be 16 or 24");
  end

  logic        rst_meta_q;
  logic        rst_n_q;
  vcia_state_s s_q;
  vcia_state_s s_d;

  // reset released through two flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'h0;
      rst_n_q    <= 1'h0;
    end else begin
      rst_meta_q <= 1'h1;
      rst_n_q    <= rst_meta_q;
    end
  end

  logic        hit;
  logic        ns_el1;
  vcia_reg_e   reg_sel;
  logic        to_virtual;
  logic        is_grp0;
  vcia_status_e gate;
  logic        eligible;
  logic [23:0] id_mask;
  logic [23:0] hppi_id_m;

  assign id_mask   = (ID_BITS == ID_NARROW) ? 24'h00ffff : 24'hffffff;
  assign hppi_id_m = hppi.interrupt_id & id_mask;
  assign id_width_field = (ID_BITS == ID_NARROW) ? ID_WIDTH_FIELD_16 : ID_WIDTH_FIELD_24;

  // shared c12 decode for the three registers
  assign hit = req.valid && req.coproc == CP_COPROC && req.crn == CP_CRN
            && req.crm == CP_CRM && req.opc1 == CP_OPC1;
  assign ns_el1 = ctx.el == EL_1 && ctx.nonsecure_state_bit;

  always_comb begin
    reg_sel = REG_NONE;
    if (hit) begin
      unique case (req.opc2)
        OPC2_ACK1: reg_sel = req.write ? REG_NONE : REG_ACK1;
        OPC2_EN0:  reg_sel = REG_EN0;
        OPC2_EN1:  reg_sel = REG_EN1;
        default:   reg_sel = REG_NONE;
      endcase
    end
  end

  assign is_grp0 = reg_sel == REG_EN0;

  // routing: virtual only at non-secure EL1 with the group's routing bit
  always_comb begin
    unique case (reg_sel)
      REG_ACK1: to_virtual = ns_el1 && ctx.hyp_irq_routing_bit;
      REG_EN0:  to_virtual = ns_el1 && ctx.hyp_fiq_routing_bit;
      REG_EN1:  to_virtual = ns_el1 && ctx.hyp_irq_routing_bit;
      default:  to_virtual = 1'h0;
    endcase
  end

  // traps and enables, highest priority first
  always_comb begin
    gate = ST_OK;
    if (reg_sel == REG_NONE) begin
      gate = ST_NOREG;
    end else if (ns_el1 && !ctx.sysreg_iface_enable_32) begin
      gate = ST_UNDEF;
    end else if (ns_el1 && !ctx.sysreg_iface_enable_el1) begin
      gate = ST_TRAP_EL1;
    end else if (ns_el1 && ctx.el2_present && ctx.hyp_c12_trap_bit) begin
      gate = ctx.el2_uses_32 ? ST_TRAP_HYP : ST_TRAP_EL2;
    end else if (ns_el1 && is_grp0 && ctx.trap_all_group0) begin
      gate = ST_TRAP_EL2;
    end else if (ns_el1 && !is_grp0 && ctx.trap_all_group1) begin
      gate = ST_TRAP_EL2;
    end else if (!to_virtual) begin
      gate = ST_PHYS;
    end
  end

  // acknowledgeable group 1 candidate, suppressed while the last ack settles
  assign eligible = hppi.valid && hppi.group1 && hppi.can_signal
                 && s_q.grp1_en && !s_q.hold;

  always_comb begin
    s_d = s_q;
    s_d.ack_valid = 1'h0;
    s_d.rsp.valid = req.valid;
    s_d.rsp.status = gate;
    s_d.rsp.target = reg_sel;
    s_d.rsp.rdata = 32'h0;
    // held off until the pending side has moved past the acked id
    if (s_q.hold && (!hppi.valid || hppi_id_m != s_q.ack_id)) begin
      s_d.hold = 1'h0;
    end
    if (gate == ST_OK) begin
      unique case (reg_sel)
        REG_ACK1: begin
          if (eligible) begin
            s_d.rsp.rdata = {8'h0, hppi_id_m};
            s_d.ack_valid = 1'h1;
            s_d.ack_id = hppi_id_m;
            s_d.hold = 1'h1;
          end else begin
            s_d.rsp.rdata = {8'h0, SPURIOUS_ID};
          end
        end
        REG_EN0: begin
          if (req.write) begin
            s_d.grp0_en = req.wdata[0];
          end
          s_d.rsp.rdata = {31'h0, s_q.grp0_en};
        end
        REG_EN1: begin
          if (req.write) begin
            s_d.grp1_en = req.wdata[0];
          end
          s_d.rsp.rdata = {31'h0, s_q.grp1_en};
        end
        default: s_d.rsp.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_q.grp0_en    <= ENABLE_RST;
      s_q.grp1_en    <= ENABLE_RST;
      s_q.rsp.valid  <= 1'h0;
      s_q.rsp.status <= ST_OK;
      s_q.rsp.target <= REG_NONE;
      s_q.rsp.rdata  <= 32'h0;
      s_q.ack_valid  <= 1'h0;
      s_q.ack_id     <= 24'h0;
      s_q.hold       <= 1'h0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign rsp          = s_q.rsp;
  assign ack_valid    = s_q.ack_valid;
  assign ack_id       = s_q.ack_id;
  assign grp0_enabled = s_q.grp0_en;
  assign grp1_enabled = s_q.grp1_en;
  // signalling gated by group enable; virq also masked after an ack
  assign virq = hppi.valid && hppi.group1 && hppi.can_signal
             && s_q.grp1_en && !s_q.hold;
  assign vfiq = hppi.valid && !hppi.group1 && hppi.can_signal
             && s_q.grp0_en;

  undef_gate_a: assert property (
    @(posedge clock) disable iff (!rst_n_q)
    clk_en && hit && reg_sel != REG_NONE && ns_el1
      && !ctx.sysreg_iface_enable_32
    |=> rsp.valid && rsp.status == ST_UNDEF)
    else $error("disabled 32-bit interface access not undefined");

  el1_trap_a: assert property (
    @(posedge clock) disable iff (!rst_n_q)
    clk_en && reg_sel != REG_NONE && ns_el1 && ctx.sysreg_iface_enable_32
      && !ctx.sysreg_iface_enable_el1
    |=> rsp.status == ST_TRAP_EL1)
    else $error("EL1 interface disable did not trap to EL1");

  c12_trap_a: assert property (
    @(posedge clock) disable iff (!rst_n_q)
    clk_en && reg_sel != REG_NONE && ns_el1 && ctx.sysreg_iface_enable_32
      && ctx.sysreg_iface_enable_el1 && ctx.el2_present
      && ctx.hyp_c12_trap_bit
    |=> rsp.status == ($past(ctx.el2_uses_32) ? ST_TRAP_HYP : ST_TRAP_EL2))
    else $error("c12 hypervisor trap not taken");

  tall_trap_a: assert property (
    @(posedge clock) disable iff (!rst_n_q)
    clk_en && gate != ST_UNDEF && gate != ST_TRAP_EL1 && gate != ST_TRAP_HYP
      && reg_sel != REG_NONE && ns_el1
      && ((is_grp0 && ctx.trap_all_group0)
        || (!is_grp0 && ctx.trap_all_group1))
    |=> rsp.status == ST_TRAP_EL2)
    else $error("trap-all group access not trapped to EL2");

  phys_route_a: assert property (
    @(posedge clock) disable iff (!rst_n_q)
    clk_en && reg_sel != REG_NONE && !ns_el1
    |=> rsp.status == ST_PHYS)
    else $error("access outside non-secure EL1 not routed physical");

  spurious_id_a: assert property (
    @(posedge clock) disable iff (!rst_n_q)
    clk_en && gate == ST_OK && reg_sel == REG_ACK1 && !eligible
    |=> rsp.rdata == {8'h0, SPURIOUS_ID} && !ack_valid)
    else $error("unobservable acknowledge did not return 1023");

  ack_data_a: assert property (
    @(posedge clock) disable iff (!rst_n_q)
    ack_valid |-> rsp.status == ST_OK && rsp.rdata[23:0] == ack_id
      && rsp.rdata[31:24] == 8'h0 && (ack_id & ~id_mask) == 24'h0)
    else $error("acknowledge data does not match acked id");

  ack_quiet_a: assert property (
    @(posedge clock) disable iff (!rst_n_q)
    ack_valid && hppi.valid && hppi_id_m == ack_id |-> !virq)
    else $error("acked interrupt still signalled");

  en0_write_a: assert property (
    @(posedge clock) disable iff (!rst_n_q)
    clk_en && gate == ST_OK && reg_sel == REG_EN0 && req.write
    |=> grp0_enabled == $past(req.wdata[0]) && rsp.rdata[31:1] == 31'h0)
    else $error("group 0 enable write not taken");

  disabled_quiet_a: assert property (
    @(posedge clock) disable iff (!rst_n_q)
    !grp1_enabled |-> !virq)
    else $error("disabled group 1 signalled");

endmodule // vcia_top

// ==== vcia_pe_model.sv ====
`timescale 1ns/10ps
module vcia_pe_model
  import vcia_pkg::*;
(
  input  wire logic      clock,
  output vcia_req_s      req,
  input  wire vcia_rsp_s rsp,
  input  wire logic      ack_valid
);
  localparam int RW = $bits(vcia_req_s);
  initial req = '0;
  // one access: launched on an edge, answer lands at the taking edge
  task automatic access(input logic w, input logic [2:0] o2,
                        input logic [31:0] wd, output vcia_rsp_s r,
                        output logic av);
    vcia_req_s q;
    @(posedge clock);
    q = '0;
    q.valid = 1'b1;
    q.write = w;
    q.opc1 = CP_OPC1;
    q.opc2 = o2;
    q.crn = CP_CRN;
    q.coproc = CP_COPROC;
    q.crm = CP_CRM;
    q.wdata = wd;
    req <= q;
    @(posedge clock);
    // released fields scrambled so stale values never pass
    req <= {1'b0, ~q[RW-2:0]};
    #1;
    r = rsp;
    av = ack_valid;
  endtask
endmodule // vcia_pe_model

// ==== tb_virtual_cpu_iface_ack_enable.sv ====
`timescale 1ns/10ps
module tb_virtual_cpu_iface_ack_enable;
  import vcia_pkg::*;
  typedef struct packed {
    vcia_ctx_s    c;
    logic [2:0]   o;
    vcia_status_e s;
    vcia_reg_e    t;
  } vcia_row_s;
  // ns el1, routed to virtual, interfaces on, no traps
  localparam vcia_ctx_s CTX_OK = 12'h7e0;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        clk_en = 1'b1;
  vcia_req_s   req;
  vcia_ctx_s   ctx;
  vcia_hppi_s  hppi;
  vcia_rsp_s   rsp;
  vcia_rsp_s   r;
  logic        ack_valid;
  logic        av;
  logic [23:0] ack_id;
  logic        virq;
  logic        vfiq;
  logic        g0_en;
  logic        g1_en;
  logic [2:0]  idw;
  int          n_fail = 0;
  int          samples_checked = 0;
  vcia_row_s   rows [10] = '{
    '{12'h6e0, OPC2_ACK1, ST_PHYS, REG_ACK1},
    '{12'h6e0, OPC2_EN1, ST_PHYS, REG_EN1},
    '{12'h760, OPC2_EN0, ST_PHYS, REG_EN0},
    '{12'hbe0, OPC2_EN0, ST_PHYS, REG_EN0},
    '{12'h7a0, OPC2_ACK1, ST_UNDEF, REG_ACK1},
    '{12'h7c0, OPC2_EN1, ST_TRAP_EL1, REG_EN1},
    '{12'h7fc, OPC2_EN0, ST_TRAP_HYP, REG_EN0},
    '{12'h7f4, OPC2_ACK1, ST_TRAP_EL2, REG_ACK1},
    '{12'h7e2, OPC2_EN0, ST_TRAP_EL2, REG_EN0},
    '{12'h7e1, OPC2_ACK1, ST_TRAP_EL2, REG_ACK1}
  };

  always #4 clock = ~clock;

  vcia_top #(.ID_BITS(16)) i_dut (
    .clock(clock), .reset_n(reset_n), .clk_en(clk_en), .req(req),
    .ctx(ctx), .hppi(hppi), .rsp(rsp), .ack_valid(ack_valid),
    .ack_id(ack_id), .virq(virq), .vfiq(vfiq), .grp0_enabled(g0_en),
    .grp1_enabled(g1_en), .id_width_field(idw)
  );

  vcia_pe_model i_pe (
    .clock(clock), .req(req), .rsp(rsp), .ack_valid(ack_valid)
  );

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic rw(input logic w, input logic [2:0] o2,
                    input logic [31:0] wd, input vcia_status_e s,
                    input vcia_reg_e t, input logic [31:0] d);
    i_pe.access(w, o2, wd, r, av);
    chk({r.valid, 7'(r.status), 4'(r.target)}, {1'b1, 7'(s), 4'(t)});
    chk(r.rdata, d);
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge clock);
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    close_out();
  end

  initial begin
    ctx = CTX_OK;
    hppi = '0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    chk(32'(idw), 32'(ID_WIDTH_FIELD_16));
    rw(1'b0, OPC2_EN0, 32'h0, ST_OK, REG_EN0, 32'h0);
    rw(1'b1, OPC2_EN0, 32'hffffffff, ST_OK, REG_EN0, 32'h0);
    rw(1'b0, OPC2_EN0, 32'h0, ST_OK, REG_EN0, 32'h1);
    rw(1'b1, OPC2_EN1, 32'hffffffff, ST_OK, REG_EN1, 32'h0);
    rw(1'b0, OPC2_EN1, 32'h0, ST_OK, REG_EN1, 32'h1);
    @(posedge clock);
    hppi <= '{1'b1, 1'b1, 1'b1, 24'hab1234};
    @(posedge clock);
    #1;
    chk(32'(virq), 32'h1);
    rw(1'b0, OPC2_ACK1, 32'h0, ST_OK, REG_ACK1, 32'h1234);
    chk({31'h0, av}, 32'h1);
    chk(32'(ack_id), 32'h1234);
    chk(32'(virq), 32'h0);
    rw(1'b0, OPC2_ACK1, 32'h0, ST_OK, REG_ACK1, 32'h3ff);
    chk({31'h0, av}, 32'h0);
    i_pe.access(1'b1, OPC2_ACK1, 32'h0, r, av);
    chk(32'(r.status), 32'(ST_NOREG));
    @(posedge clock);
    hppi <= '{1'b1, 1'b1, 1'b1, 24'h000055};
    foreach (rows[i]) begin
      @(posedge clock);
      ctx <= rows[i].c;
      rw(rows[i].o != OPC2_ACK1, rows[i].o, 32'h0, rows[i].s, rows[i].t,
         32'h0);
      chk({31'h0, av}, 32'h0);
    end
    @(posedge clock);
    ctx <= CTX_OK;
    @(posedge clock);
    #1;
    chk({30'h0, g0_en, g1_en}, 32'h3);
    chk(32'(virq), 32'h1);
    rw(1'b1, OPC2_EN1, 32'h0, ST_OK, REG_EN1, 32'h1);
    chk(32'(virq), 32'h0);
    rw(1'b0, OPC2_ACK1, 32'h0, ST_OK, REG_ACK1, 32'h3ff);
    @(posedge clock);
    hppi <= '{1'b1, 1'b0, 1'b1, 24'h000042};
    @(posedge clock);
    #1;
    chk(32'(vfiq), 32'h1);
    // frozen clock enable: the write must not land
    @(posedge clock);
    clk_en <= 1'b0;
    i_pe.access(1'b1, OPC2_EN0, 32'h0, r, av);
    chk({31'h0, r.valid}, 32'h0);
    chk({31'h0, g0_en}, 32'h1);
    @(posedge clock);
    clk_en <= 1'b1;
    rw(1'b1, OPC2_EN0, 32'h0, ST_OK, REG_EN0, 32'h1);
    chk(32'(vfiq), 32'h0);
    close_out();
  end
endmodule // tb_virtual_cpu_iface_ack_enable
